// File: inc/acc_pkg.sv
// Purpose: shared constants and types of the secure memory access controller
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: offsets, control, command, address and zone field positions, three reset values and the security counts are named here once
package acc_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_CMD = 8'h08;
   localparam logic [7:0] OFF_ACC_ADDR = 8'h0c;
   localparam logic [7:0] OFF_ACC_DATA = 8'h10;
   localparam logic [7:0] OFF_ACC_RES = 8'h14;
   localparam logic [1:0] ZONE_PAGE = 2'h1;
   // control bits
   localparam int CT_TEAR = 0;
   localparam int CT_SUPV = 1;
   localparam logic [1:0] CTRL_RST = 2'h0;
   // command word fields
   localparam int CM_OP = 0;
   localparam int CM_IDX = 3;
   localparam int CM_WR = 6;
   localparam int CM_OK = 7;
   localparam int CM_CODE = 8;
   localparam logic [2:0] OP_PW = 3'h1;
   localparam logic [2:0] OP_AUTH = 3'h2;
   localparam logic [2:0] OP_ENC = 3'h3;
   localparam logic [2:0] OP_MAC = 3'h4;
   localparam logic [2:0] OP_CODE = 3'h5;
   // access address fields
   localparam int AA_READ = 16;
   localparam int AA_CFG = 17;
   localparam int AA_PWA = 18;
   localparam logic [18:0] ACC_ADDR_RST = 19'h0;
   // zone configuration fields
   localparam int ZC_WLOCK = 0;
   localparam int ZC_MODF = 1;
   localparam int ZC_PROG = 2;
   localparam int ZC_ENC = 3;
   localparam int ZC_PWEN = 4;
   localparam int ZC_AUEN = 5;
   localparam int ZC_PWSET = 6;
   localparam int ZC_KEY = 9;
   localparam int ZC_W = 11;
   localparam logic [ZC_W-1:0] ZCFG_RST = 11'h0;
   // security figures
   localparam logic [2:0] TRIAL_MAX = 3'h4;
   localparam logic [7:0] TEAR_MAX_BYTES = 8'h08;
   localparam logic [2:0] SUPV_PW = 3'h0;
   localparam logic [2:0] LINK_PULSES = 3'h5;
   // arbitrary neutral value for the device secure code
   localparam logic [23:0] SECURE_CODE = 24'h5a3c96;
   typedef enum logic [1:0] {M_STD, M_AUTH, M_ENC} mode_t;
endpackage

// File: verilog/acc_ctrl.sv
// Purpose: security state and access control of a secure serial memory
// Assumes: command engine and NVM writer share pclk; scl and reset pin are async
// Notes: software reports each credential result through the command register
//
// What this block does
// - power-up defaults to 2-wire, reset pin high
// - standard mode, then authentication, then encryption
// - select clear, encrypted and MAC/MDC per mode
// - anti-tearing limits writes to eight bytes
// - anti-tearing writes buffer first, then target
// - interrupted target write restored at next power-up
// - page lock byte bit clear locks byte
// - lock byte bit0 locks itself, program-only
// - write-lock zone writes only first byte
// - valid password held until reset or new
// - eight password sets, one active, write reads
// - zone key choice, failed retry cancels authentication
// - four failures block further attempts
// - MAC mismatch abandons command, leaves secure mode
// - encryption-required zone needs encryption mode
// - supervisor password reaches all password sets
// - modify-forbidden rejects writes, program-only clears bits
// - configuration memory needs the secure code
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module acc_ctrl
   import acc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl,
   input wire logic rst_pin_n,
   input wire logic tear_mark_nv,
   input wire logic nvm_done,
   output logic nvm_buf_wr,
   output logic nvm_tgt_wr,
   output logic nvm_restore,
   output logic tear_mark,
   output logic [12:0] nvm_addr,
   output logic [7:0] nvm_data,
   output logic [7:0] nvm_len,
   output logic twi_sel,
   output logic link_ready
);
   import acc_pkg::*;

   typedef enum logic [1:0] {T_IDLE, T_BUF, T_TGT, T_REC} tear_t;

   logic scl_s1_q, scl_s2_q, scl_s3_q;
   logic rpin_s1_q, rpin_s2_q;
   logic [2:0] pulse_cnt_q;
   logic link_ready_q;
   logic boot_q;
   logic twi_sel_q;
   logic pready_q, pslverr_q;
   logic [31:0] prdata_q, rd_mux;
   logic rd_hit;
   logic [1:0] ctrl_q;
   logic [ZC_W-1:0] zcfg_q [16];
   logic [18:0] acc_addr_q;
   mode_t mode_q;
   logic pw_valid_q, pw_wr_q, auth_valid_q, secure_ok_q, abandon_q;
   logic [2:0] pw_idx_q;
   logic [1:0] auth_key_q;
   logic [2:0] pw_fail_q [8];
   logic [2:0] key_fail_q [4];
   logic granted_q;
   logic [7:0] res_byte_q, res_cnt_q;
   tear_t tear_q;
   logic buf_wr_q, tgt_wr_q, restore_q, mark_q;
   logic [12:0] nvm_addr_q;
   logic [7:0] nvm_data_q, nvm_len_q;

   logic acc_w, cmd_w, data_w, sec_clr, busy;
   logic [2:0] op, idx;
   logic ok;
   logic [ZC_W-1:0] zc;
   logic [2:0] off;
   logic rd, pw_ok, au_ok, en_ok, wr_ok, cfg_ok, grant;
   logic [7:0] n_new, n_old, n_lock, n_req, cnt, rbyte;

   function automatic logic [2:0] trial_next(input logic [2:0] c, input logic pass);
      if (pass)
         return 3'h0;
      return (c == TRIAL_MAX) ? c : c + 3'h1;
   endfunction

   // scl and the reset pin come from outside; only s2 and later are looked at
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // reset to the idle-high level so release does not fake a clock edge
         scl_s1_q <= 1'b1;
         scl_s2_q <= 1'b1;
         scl_s3_q <= 1'b1;
         rpin_s1_q <= 1'b1;
         rpin_s2_q <= 1'b1;
      end else begin
         scl_s1_q <= scl;
         scl_s2_q <= scl_s1_q;
         scl_s3_q <= scl_s2_q;
         rpin_s1_q <= rst_pin_n;
         rpin_s2_q <= rpin_s1_q;
      end
   end

   // count the host's opening clocks; readiness is only reported, never enforced
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_cnt_q <= 3'h0;
         link_ready_q <= 1'b0;
      end else if (!link_ready_q && scl_s2_q && !scl_s3_q) begin
         pulse_cnt_q <= pulse_cnt_q + 3'h1;
         if (pulse_cnt_q + 3'h1 == LINK_PULSES)
            link_ready_q <= 1'b1;
      end
   end

   // protocol pick once after release; the pull-up makes 2-wire the default
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot_q <= 1'b0;
         twi_sel_q <= 1'b1;
      end else if (!boot_q) begin
         boot_q <= 1'b1;
         twi_sel_q <= rpin_s2_q;
      end
   end

   assign sec_clr = !rpin_s2_q;
   assign acc_w = psel && penable && pwrite && pready_q;
   assign cmd_w = acc_w && paddr[7:0] == OFF_CMD;
   assign data_w = acc_w && paddr[7:0] == OFF_ACC_DATA;
   assign op = pwdata[CM_OP +: 3];
   assign idx = pwdata[CM_IDX +: 3];
   assign ok = pwdata[CM_OK];

   always_comb begin
      rd_hit = 1'b1;
      rd_mux = 32'h0;
      if (paddr[7:6] == ZONE_PAGE)
         rd_mux = {21'h0, zcfg_q[paddr[5:2]]};
      else
         case (paddr[7:0])
            OFF_CTRL: rd_mux = {30'h0, ctrl_q};
            OFF_STATUS: rd_mux = {16'h0, busy, mark_q, abandon_q, twi_sel_q,
                                  link_ready_q, secure_ok_q, auth_key_q, auth_valid_q,
                                  pw_wr_q, pw_idx_q, pw_valid_q, mode_q};
            OFF_CMD, OFF_ACC_DATA: rd_mux = 32'h0;
            OFF_ACC_ADDR: rd_mux = {13'h0, acc_addr_q};
            OFF_ACC_RES: rd_mux = {8'h0, res_cnt_q, res_byte_q, 4'h0,
                                   mode_q != M_STD, mode_q != M_STD,
                                   mode_q == M_ENC, granted_q};
            default: rd_hit = 1'b0;
         endcase
   end

   // one access cycle, no wait states; unmapped addresses answer with an error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= psel && !penable;
         pslverr_q <= psel && !penable && !rd_hit;
         if (psel && !penable && !pwrite)
            prdata_q <= rd_mux;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RST;
         acc_addr_q <= ACC_ADDR_RST;
         for (int i = 0; i < 16; i++)
            zcfg_q[i] <= ZCFG_RST;
      end else if (acc_w) begin
         if (paddr[7:6] == ZONE_PAGE)
            zcfg_q[paddr[5:2]] <= pwdata[ZC_W-1:0];
         else if (paddr[7:0] == OFF_CTRL)
            ctrl_q <= pwdata[1:0];
         else if (paddr[7:0] == OFF_ACC_ADDR)
            acc_addr_q <= pwdata[18:0];
      end
   end

   // credential and mode state; the reset pin clears mode and valid flags but keeps the trial counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= M_STD;
         pw_valid_q <= 1'b0;
         pw_wr_q <= 1'b0;
         pw_idx_q <= 3'h0;
         auth_valid_q <= 1'b0;
         auth_key_q <= 2'h0;
         secure_ok_q <= 1'b0;
         abandon_q <= 1'b0;
         for (int i = 0; i < 8; i++)
            pw_fail_q[i] <= 3'h0;
         for (int i = 0; i < 4; i++)
            key_fail_q[i] <= 3'h0;
      end else if (sec_clr) begin
         // trial counters survive, so pulsing the pin buys no fresh attempts
         mode_q <= M_STD;
         pw_valid_q <= 1'b0;
         auth_valid_q <= 1'b0;
         secure_ok_q <= 1'b0;
         abandon_q <= 1'b0;
      end else if (cmd_w) begin
         abandon_q <= 1'b0;
         case (op)
            OP_PW: begin
               if (pw_fail_q[idx] != TRIAL_MAX) begin
                  pw_fail_q[idx] <= trial_next(pw_fail_q[idx], ok);
                  pw_valid_q <= ok;
                  pw_idx_q <= idx;
                  pw_wr_q <= pwdata[CM_WR];
               end
            end
            OP_AUTH: begin
               if (key_fail_q[idx[1:0]] != TRIAL_MAX) begin
                  key_fail_q[idx[1:0]] <= trial_next(key_fail_q[idx[1:0]], ok);
                  auth_valid_q <= ok;
                  auth_key_q <= idx[1:0];
                  mode_q <= ok ? M_AUTH : M_STD;
               end
            end
            OP_ENC: begin
               if (ok && auth_valid_q && mode_q != M_STD)
                  mode_q <= M_ENC;
            end
            OP_MAC: begin
               if (!ok && mode_q != M_STD) begin
                  mode_q <= M_STD;
                  auth_valid_q <= 1'b0;
                  abandon_q <= 1'b1;
               end
            end
            OP_CODE: begin
               if (pwdata[CM_CODE +: 24] == SECURE_CODE)
                  secure_ok_q <= 1'b1;
            end
            default: abandon_q <= 1'b0;
         endcase
      end
   end

   // access decision for the address and data the engine presents
   assign busy = tear_q != T_IDLE;
   assign zc = zcfg_q[acc_addr_q[12:9]];
   assign off = acc_addr_q[2:0];
   assign rd = acc_addr_q[AA_READ];
   assign n_new = pwdata[7:0];
   assign n_old = pwdata[15:8];
   assign n_lock = pwdata[23:16];
   assign n_req = pwdata[31:24];

   always_comb begin
      pw_ok = !zc[ZC_PWEN] || (pw_valid_q && pw_idx_q == zc[ZC_PWSET +: 3]
                               && (rd || pw_wr_q));
      au_ok = !zc[ZC_AUEN] || (auth_valid_q && auth_key_q == zc[ZC_KEY +: 2]);
      en_ok = !zc[ZC_ENC] || mode_q == M_ENC;
      wr_ok = !zc[ZC_MODF] && (!zc[ZC_WLOCK] || n_lock[off]);
      cfg_ok = secure_ok_q;
      if (acc_addr_q[AA_PWA] && ctrl_q[CT_SUPV] && pw_valid_q && pw_wr_q
          && pw_idx_q == SUPV_PW)
         cfg_ok = 1'b1;
      if (acc_addr_q[AA_CFG])
         grant = !busy && cfg_ok && !abandon_q;
      else
         grant = !busy && !abandon_q && pw_ok && au_ok && en_ok && (rd || wr_ok);
      // lock bytes and program-only zones may only clear bits
      if (!acc_addr_q[AA_CFG] && (zc[ZC_PROG] || (zc[ZC_WLOCK] && off == 3'h0)))
         rbyte = n_old & n_new;
      else
         rbyte = n_new;
      if (!acc_addr_q[AA_CFG] && zc[ZC_WLOCK])
         cnt = (n_req == 8'h0) ? 8'h0 : 8'h1;
      else if (ctrl_q[CT_TEAR] && n_req > TEAR_MAX_BYTES)
         cnt = TEAR_MAX_BYTES;
      else
         cnt = n_req;
      if (rd)
         cnt = n_req;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         granted_q <= 1'b0;
         res_byte_q <= 8'h0;
         res_cnt_q <= 8'h0;
      end else if (data_w) begin
         granted_q <= grant;
         res_byte_q <= rbyte;
         res_cnt_q <= grant ? cnt : 8'h0;
      end
   end

   // write sequencer; with anti-tearing the buffer copy lands before the target
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tear_q <= T_IDLE;
         buf_wr_q <= 1'b0;
         tgt_wr_q <= 1'b0;
         restore_q <= 1'b0;
         mark_q <= 1'b0;
         nvm_addr_q <= 13'h0;
         nvm_data_q <= 8'h0;
         nvm_len_q <= 8'h0;
      end else begin
         buf_wr_q <= 1'b0;
         tgt_wr_q <= 1'b0;
         restore_q <= 1'b0;
         case (tear_q)
            T_IDLE: begin
               if (!boot_q && tear_mark_nv) begin
                  tear_q <= T_REC;
                  restore_q <= 1'b1;
                  mark_q <= 1'b1;
               end else if (data_w && grant && !rd && cnt != 8'h0) begin
                  nvm_addr_q <= acc_addr_q[12:0];
                  nvm_data_q <= rbyte;
                  nvm_len_q <= cnt;
                  if (ctrl_q[CT_TEAR]) begin
                     tear_q <= T_BUF;
                     buf_wr_q <= 1'b1;
                  end else begin
                     tear_q <= T_TGT;
                     tgt_wr_q <= 1'b1;
                  end
               end
            end
            T_BUF: begin
               if (nvm_done) begin
                  tear_q <= T_TGT;
                  tgt_wr_q <= 1'b1;
                  mark_q <= 1'b1;
               end
            end
            T_TGT, T_REC: begin
               // mark stays up until the target copy is known complete
               if (nvm_done) begin
                  tear_q <= T_IDLE;
                  mark_q <= 1'b0;
               end
            end
            default: tear_q <= T_IDLE;
         endcase
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign nvm_buf_wr = buf_wr_q;
   assign nvm_tgt_wr = tgt_wr_q;
   assign nvm_restore = restore_q;
   assign tear_mark = mark_q;
   assign nvm_addr = nvm_addr_q;
   assign nvm_data = nvm_data_q;
   assign nvm_len = nvm_len_q;
   assign twi_sel = twi_sel_q;
   assign link_ready = link_ready_q;
endmodule // acc_ctrl

// File: tb/acc_ctrl_props.sv
// Purpose: concurrent checks on the memory-write and link outputs of acc_ctrl
// Assumes: scl is counted raw here, so this count leads the design's synced one
// Notes: age_q counts edges since reset release and stops at three
`timescale 1ns/10ps
module acc_ctrl_props
   import acc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic scl,
   input wire logic tear_mark_nv,
   input wire logic nvm_done,
   input wire logic nvm_buf_wr,
   input wire logic nvm_tgt_wr,
   input wire logic nvm_restore,
   input wire logic tear_mark,
   input wire logic [7:0] nvm_len,
   input wire logic twi_sel,
   input wire logic link_ready
);
   logic [1:0] age_q;
   logic [2:0] rises_q;
   logic scl_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         age_q <= 2'h0;
      end else if (age_q != 2'h3) begin
         age_q <= age_q + 2'h1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_q <= 1'b1;
         rises_q <= 3'h0;
      end else begin
         scl_q <= scl;
         if (scl && !scl_q && rises_q != 3'h7) begin
            rises_q <= rises_q + 3'h1;
         end
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   twi_up_a: assert property (age_q == 2'h1 |-> twi_sel)
      else $error("two-wire not selected after reset");
   link_cnt_a: assert property (link_ready |-> rises_q >= 3'h5)
      else $error("link ready before five clocks");
   buf_len_a: assert property (nvm_buf_wr |-> nvm_len != 8'h00 && nvm_len <= TEAR_MAX_BYTES)
      else $error("buffered length out of range");
   tgt_order_a: assert property (nvm_tgt_wr && tear_mark |-> $past(nvm_done))
      else $error("target write before buffer done");
   mark_rise_a: assert property ($rose(tear_mark) |-> nvm_tgt_wr || nvm_restore)
      else $error("tear mark rose without a write");
   mark_fall_a: assert property ($fell(tear_mark) |-> $past(nvm_done))
      else $error("tear mark fell before completion");
   mark_hold_a: assert property (tear_mark && !nvm_done |=> tear_mark)
      else $error("tear mark dropped early");
   restore_a: assert property (nvm_restore || age_q == 2'h1 |->
      age_q == 2'h1 && nvm_restore == $past(tear_mark_nv))
      else $error("restore does not follow the tear flag");
endmodule // acc_ctrl_props
bind acc_ctrl acc_ctrl_props i_acc_ctrl_props (.pclk(pclk), .presetn(presetn), .scl(scl),
   .tear_mark_nv(tear_mark_nv), .nvm_done(nvm_done), .nvm_buf_wr(nvm_buf_wr),
   .nvm_tgt_wr(nvm_tgt_wr), .nvm_restore(nvm_restore), .tear_mark(tear_mark),
   .nvm_len(nvm_len), .twi_sel(twi_sel), .link_ready(link_ready));

// File: tb/host_nvm_model.sv
// Purpose: host link clock and nonvolatile memory timing seen by acc_ctrl
// Assumes: one memory operation at a time
// Notes: random completion delay gives both prompt and slow memory
`timescale 1ns/10ps
module host_nvm_model (
   input wire logic pclk,
   output logic scl,
   input wire logic nvm_buf_wr,
   input wire logic nvm_tgt_wr,
   input wire logic nvm_restore,
   output logic nvm_done
);
   logic [3:0] wait_q = 4'h0;
   // clock idles high between frames, held by the bus pull-up
   initial scl = 1'b1;
   initial nvm_done = 1'b0;
   task automatic pulses(input int n);
      #5;
      repeat (n) begin
         scl = 1'b0;
         #160;
         scl = 1'b1;
         #160;
      end
   endtask
   always @(posedge pclk) begin
      nvm_done <= (wait_q == 4'h1);
      if (nvm_buf_wr || nvm_tgt_wr || nvm_restore) begin
         wait_q <= 4'(2 + $urandom_range(0, 6));
      end else if (wait_q != 4'h0) begin
         wait_q <= wait_q - 4'h1;
      end
   end
endmodule // host_nvm_model

// File: tb/acc_ctrl_tb.sv
// Purpose: self-checking bench for acc_ctrl over APB
// Assumes: expectations come from the access rules and package constants
// Notes: probe accesses use a zero count so they launch no memory write
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
   $display("FAIL t=%0t got %h exp %h", $time, (a), (e)); end end
module acc_ctrl_tb;
   import acc_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rst_pin_n = 1;
   logic tear_mark_nv = 0, pready, pslverr, scl, nvm_done, nvm_restore, err;
   logic nvm_buf_wr, nvm_tgt_wr, tear_mark;
   logic [12:0] nvm_addr;
   logic [7:0] nvm_data, nvm_len;
   // expected memory launches: address, byte, count
   logic [28:0] exp_w;
   logic [28:0] exp_q[$];
   logic [31:0] paddr = 0, pwdata = 0, prdata, r;
   logic [7:0] nb;
   int num_errors = 0, checked = 0, restores = 0, g, m;
   always #20 pclk = ~pclk;
   always @(posedge pclk) if (nvm_restore) restores++;
   always @(posedge pclk) begin
      if (nvm_buf_wr || (nvm_tgt_wr && !tear_mark)) begin
         `CHK(exp_q.size() > 0, 1'b1)
         if (exp_q.size() > 0) begin
            exp_w = exp_q.pop_front();
            `CHK({nvm_addr, nvm_data, nvm_len}, exp_w)
         end
      end
   end
   acc_ctrl i_acc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .scl(scl), .rst_pin_n(rst_pin_n), .tear_mark_nv(tear_mark_nv),
      .nvm_done(nvm_done), .nvm_buf_wr(nvm_buf_wr), .nvm_tgt_wr(nvm_tgt_wr),
      .nvm_restore(nvm_restore), .tear_mark(tear_mark), .nvm_addr(nvm_addr),
      .nvm_data(nvm_data), .nvm_len(nvm_len),
      .twi_sel(), .link_ready());
   host_nvm_model i_host_nvm_model (.pclk(pclk), .scl(scl), .nvm_buf_wr(nvm_buf_wr),
      .nvm_tgt_wr(nvm_tgt_wr), .nvm_restore(nvm_restore), .nvm_done(nvm_done));
   // a free edge first keeps psel from being driven twice in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait that never sees pready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic acc(input logic [31:0] a, input logic [31:0] d);
      apb(1'b1, OFF_ACC_ADDR, a);
      apb(1'b1, OFF_ACC_DATA, d);
      apb(1'b0, OFF_ACC_RES, 32'h0);
   endtask
   task automatic idle();
      int k;
      for (k = 0; k < 100; k++) begin
         apb(1'b0, OFF_STATUS, 32'h0);
         if (r[15] === 1'b0) break;
      end
      if (k == 100) num_errors++;
   endtask
   task automatic step(input logic [31:0] c, input int em, input logic eg);
      apb(1'b1, OFF_CMD, c);
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK(r[1:0], em[1:0])
      acc(32'h10000, 32'h0);
      `CHK(r[3:0], {em != 0, em != 0, em == 2, eg})
   endtask
   // ok set means the right code too, so one flag drives every check
   function automatic logic [31:0] cmd(logic [2:0] op, logic [2:0] ix, logic ok);
      return {SECURE_CODE ^ {23'h0, !ok}, ok, 1'b1, ix, op};
   endfunction
   task automatic test_end(input string s);
      $display("test %s ends", s);
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // all tests need well under 100 us
   initial begin
      #500000;
      num_errors++;
      wrap_up();
   end
   initial begin
      void'($urandom(95));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK(r, 32'h1000)
      apb(1'b0, 8'h3c, 32'h0);
      `CHK({err, r}, 33'h100000000)
      i_host_nvm_model.pulses(4);
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK(r[11], 1'b0)
      i_host_nvm_model.pulses(1);
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK(r[11], 1'b1)
      test_end("reset and link");
      for (m = 0; m < 3; m++) begin
         if (m > 0) apb(1'b1, OFF_CMD, cmd(OP_CODE, 3'h0, m == 2));
         acc(32'h20000, 32'h0);
         `CHK(r[0], m == 2)
      end
      step(cmd(OP_ENC, 3'h0, 1'b1), 0, 1'b1);
      step(cmd(OP_AUTH, 3'h1, 1'b1), 1, 1'b1);
      step(cmd(OP_ENC, 3'h1, 1'b1), 2, 1'b1);
      step(cmd(OP_MAC, 3'h0, 1'b1), 2, 1'b1);
      step(cmd(OP_MAC, 3'h0, 1'b0), 0, 1'b0);
      step(cmd(OP_AUTH, 3'h1, 1'b1), 1, 1'b1);
      step(cmd(OP_AUTH, 3'h1, 1'b0), 0, 1'b1);
      for (m = 0; m < 4; m++) step(cmd(OP_AUTH, 3'h2, 1'b0), 0, 1'b1);
      step(cmd(OP_AUTH, 3'h2, 1'b1), 0, 1'b1);
      m = $urandom_range(0, 7);
      apb(1'b1, OFF_CMD, cmd(OP_PW, m[2:0], 1'b1));
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK(r[7:0], {2'b01, m[2:0], 3'b100})
      rst_pin_n <= 1'b0;
      repeat (4) @(posedge pclk);
      rst_pin_n <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK({r[10], r[7], r[2:0]}, 5'h00)
      apb(1'b1, OFF_CMD, cmd(OP_PW, SUPV_PW, 1'b1));
      for (m = 0; m < 2; m++) begin
         apb(1'b1, OFF_CTRL, {30'h0, m[0], 1'b0});
         acc(32'h60000, 32'h0);
         `CHK(r[0], m[0])
      end
      test_end("credentials");
      nb = 8'($urandom);
      apb(1'b1, OFF_CTRL, 32'h1);
      exp_q.push_back({13'h5, nb, TEAR_MAX_BYTES});
      acc(32'h5, {8'h0c, 16'h0, nb});
      `CHK({r[23:8], r[0]}, {TEAR_MAX_BYTES, nb, 1'b1})
      idle();
      apb(1'b1, OFF_CTRL, 32'h0);
      apb(1'b1, 8'h40, 32'h1);
      for (m = 0; m < 8; m++) begin
         nb = 8'($urandom);
         g = (8'hd9 >> m) & 1;
         if (g == 1) exp_q.push_back({10'h0, m[2:0], (m == 0) ? (8'hd9 & nb) : nb, 8'h01});
         acc({29'h0, m[2:0]}, {8'h03, 8'hd9, 8'hd9, nb});
         `CHK(r[0], g[0])
         if (g == 1) `CHK(r[23:8], {8'h01, (m == 0) ? (8'hd9 & nb) : nb})
         idle();
      end
      for (m = 0; m < 3; m++) begin
         nb = 8'($urandom);
         apb(1'b1, 8'h44, 32'h2 << m);
         if (m == 1) exp_q.push_back({13'h201, 8'h5a & nb, 8'h01});
         acc(32'h201, {8'h01, 8'hff, 8'h5a, nb});
         `CHK(r[0], m == 1)
         if (m == 1) `CHK(r[15:8], 8'h5a & nb)
         idle();
      end
      `CHK(exp_q.size(), 0)
      test_end("writes");
      tear_mark_nv <= 1'b1;
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      tear_mark_nv <= 1'b0;
      idle();
      `CHK(restores, 1)
      `CHK(r[15:14], 2'b00)
      test_end("restore");
      wrap_up();
   end
endmodule // acc_ctrl_tb
